// >>> flash_wp_pkg.sv
// package: constants for the flash write-protection block
package flash_wp_pkg;

    // ------------------------------------------------------------
    // command opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_EN = 8'h06;
    localparam logic [7:0] CMD_WRDI     = 8'h04;
    localparam logic [7:0] CMD_WRSR     = 8'h01;
    localparam logic [7:0] CMD_PP       = 8'h02;
    localparam logic [7:0] CMD_PP4B     = 8'h12;
    localparam logic [7:0] CMD_QPP      = 8'h38;
    localparam logic [7:0] CMD_QPP4B    = 8'h3E;
    localparam logic [7:0] CMD_SE       = 8'h20;
    localparam logic [7:0] CMD_SE4B     = 8'h21;
    localparam logic [7:0] CMD_BE32     = 8'h52;
    localparam logic [7:0] CMD_BE32_4B  = 8'h5C;
    localparam logic [7:0] CMD_BE       = 8'hD8;
    localparam logic [7:0] CMD_BE4B     = 8'hDC;
    localparam logic [7:0] CMD_CE       = 8'h60;
    localparam logic [7:0] CMD_CE2      = 8'hC7;
    localparam logic [7:0] CMD_DP       = 8'hB9;
    localparam logic [7:0] CMD_WAKE     = 8'hAB;
    localparam logic [7:0] CMD_SUSP     = 8'hB0;
    localparam logic [7:0] CMD_RESUME   = 8'h30;
    localparam logic [7:0] CMD_RSTEN    = 8'h66;
    localparam logic [7:0] CMD_RST      = 8'h99;
    localparam logic [7:0] CMD_ENSO     = 8'hB1;
    localparam logic [7:0] CMD_EXSO     = 8'hC1;
    localparam logic [7:0] CMD_SECUR_WR = 8'h2F;

    // ------------------------------------------------------------
    // APB register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_SECUR    = 8'h08;
    localparam logic [7:0] REG_LAST     = 8'h0C;
    localparam logic [7:0] REG_SECTLK   = 8'h10;

    // ctrl fields
    localparam int CTRL_BP_LSB  = 0;
    localparam int CTRL_TB      = 4;
    localparam int CTRL_SRWD    = 5;
    localparam int CTRL_QUAD    = 6;
    localparam int CTRL_QCMD    = 7;
    // security register fields
    localparam int SEC_FLOCK    = 0;
    localparam int SEC_CLOCK    = 1;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ADDR_W        = 25;
    localparam int BLK_LSB       = 16;
    localparam int B32_LSB       = 15;
    localparam int SECT_LSB      = 12;
    localparam int TOP_SECTS     = 16;
    localparam logic [8:0] TOP_BLOCK = 9'h1FF;
    localparam logic [3:0] BP_ALL_MIN = 4'hA;
    localparam int OTP_CUST_BIT  = 9;

    // reset values
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [15:0] SECTLK_RST = 16'h0000;

    // verdict codes
    localparam logic [2:0] V_NONE    = 3'h0;
    localparam logic [2:0] V_EXEC    = 3'h1;
    localparam logic [2:0] V_LENGTH  = 3'h2;
    localparam logic [2:0] V_NOWEL   = 3'h3;
    localparam logic [2:0] V_PROT    = 3'h4;
    localparam logic [2:0] V_DPD     = 3'h5;
    localparam logic [2:0] V_OTPLOCK = 3'h6;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_CMD     = 3'b010,
        ST_DPD     = 3'b100
    } wp_state_e;

endpackage : flash_wp_pkg

// >>> flash_wp.sv
// write-protection gate of a serial nor flash
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module flash_wp (
    input  wire logic                           mclk_i,
    input  wire logic                           reset_n_i,
    // command frame from the serial decoder (same clock)
    input  wire logic                           cmd_valid_i,
    input  wire logic [7:0]                     cmd_opcode_i,
    input  wire logic [flash_wp_pkg::ADDR_W-1:0] cmd_addr_i,
    input  wire logic [7:0]                     cmd_data_i,
    input  wire logic                           cmd_byte_aligned_i,
    input  wire logic                           factory_lock_i,
    input  wire logic                           write_protect_n_i,
    // apb slave
    input  wire logic                           psel_i,
    input  wire logic                           penable_i,
    input  wire logic                           pwrite_i,
    input  wire logic [7:0]                     paddr_i,
    input  wire logic [31:0]                    pwdata_i,
    output logic      [31:0]                    prdata_o,
    output logic                                pready_o,
    output logic                                pslverr_o,
    // verdicts
    output logic                                exec_o,
    output logic                                exec_otp_o,
    output logic                                reject_o,
    output logic      [2:0]                     verdict_o,
    output logic                                write_enable_latch_o,
    output logic                                otp_mode_o,
    output logic                                deep_power_down_o
);
    import flash_wp_pkg::*;

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    logic wp_meta_q;
    logic wp_sync_q;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wp_meta_q <= 1'b1;
            wp_sync_q <= 1'b1;
        end else begin
            wp_meta_q <= write_protect_n_i;
            wp_sync_q <= wp_meta_q;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    wp_state_e   state_q;
    wp_state_e   state_d;
    logic [7:0]  ctrl_q;
    logic [15:0] sectlk_q;
    logic        latch_q;
    logic        otp_q;
    logic        clock_q;
    logic        flock_q;
    logic [2:0]  verdict_q;
    logic [7:0]  last_op_q;

    // ------------------------------------------------------------
    // address decode and protected range
    // ------------------------------------------------------------
    wire [3:0]  bp_lvl   = ctrl_q[CTRL_BP_LSB +: 4];
    wire        tb_bit   = ctrl_q[CTRL_TB];
    wire [12:0] sect_idx = cmd_addr_i[ADDR_W-1:SECT_LSB];
    wire [9:0]  b32_idx  = cmd_addr_i[ADDR_W-1:B32_LSB];
    wire [8:0]  blk_idx  = cmd_addr_i[ADDR_W-1:BLK_LSB];

    // mask of low bits that may vary inside the protected span
    wire [8:0]  span_m   = (bp_lvl == 4'h0) ? 9'h000
                         : 9'((10'h001 << (bp_lvl - 4'h1)) - 10'h001);
    wire        hit_top  = ((blk_idx | span_m) == TOP_BLOCK);
    wire        hit_bot  = ((blk_idx & ~span_m) == 9'h000);
    wire        all_prot = (bp_lvl >= BP_ALL_MIN);
    wire        blk_prot = all_prot
                         || (bp_lvl != 4'h0 && (tb_bit ? hit_bot : hit_top));
    // top sectors use their own lock bits
    wire        in_top_s = (sect_idx >= 13'(13'h1FFF - (TOP_SECTS - 1)));
    wire        sect_lk  = in_top_s && sectlk_q[sect_idx[3:0]];
    // an erase covering a locked top sector is refused as well
    wire [7:0]  half_lk  = b32_idx[0] ? sectlk_q[15:8] : sectlk_q[7:0];
    wire        span_lk  = (b32_idx[9:1] == 9'h1FF) && (half_lk != 8'h00);
    wire        blk_lk   = (blk_idx == TOP_BLOCK) && (sectlk_q != 16'h0000);

    // ------------------------------------------------------------
    // command classes
    // ------------------------------------------------------------
    wire is_prog  = (cmd_opcode_i == CMD_PP) || (cmd_opcode_i == CMD_PP4B)
                 || (cmd_opcode_i == CMD_QPP) || (cmd_opcode_i == CMD_QPP4B);
    wire is_sect  = (cmd_opcode_i == CMD_SE) || (cmd_opcode_i == CMD_SE4B);
    wire is_b32   = (cmd_opcode_i == CMD_BE32)
                 || (cmd_opcode_i == CMD_BE32_4B);
    wire is_blk   = (cmd_opcode_i == CMD_BE) || (cmd_opcode_i == CMD_BE4B);
    wire is_chip  = (cmd_opcode_i == CMD_CE) || (cmd_opcode_i == CMD_CE2);
    wire is_wrsr  = (cmd_opcode_i == CMD_WRSR);
    wire is_scur  = (cmd_opcode_i == CMD_SECUR_WR);
    wire needs_latch = is_prog || is_sect || is_b32 || is_blk || is_chip
                  || is_wrsr || is_scur;
    wire dpd_ok   = (cmd_opcode_i == CMD_WAKE) || (cmd_opcode_i == CMD_SUSP)
                 || (cmd_opcode_i == CMD_RESUME)
                 || (cmd_opcode_i == CMD_RSTEN) || (cmd_opcode_i == CMD_RST);

    wire arr_prot = (is_prog && (blk_prot || sect_lk))
                 || (is_sect && (blk_prot || sect_lk))
                 || (is_b32 && (blk_prot || span_lk))
                 || (is_blk && (blk_prot || blk_lk))
                 || (is_chip && (bp_lvl != 4'h0 || sectlk_q != 16'h0000));

    // locked otp halves; bit 9 picks the half
    wire otp_fact = cmd_addr_i[OTP_CUST_BIT];
    wire otp_lk   = otp_fact ? flock_q : clock_q;

    // pin loses its meaning in quad modes
    wire pin_lock = ~wp_sync_q && ctrl_q[CTRL_SRWD]
                 && ~ctrl_q[CTRL_QUAD] && ~ctrl_q[CTRL_QCMD];

    // ------------------------------------------------------------
    // verdict
    // ------------------------------------------------------------
    logic [2:0] verdict_d;
    always_comb begin
        verdict_d = V_EXEC;
        if (state_q == ST_DPD && !dpd_ok) begin
            verdict_d = V_DPD;
        end else if (!cmd_byte_aligned_i) begin
            verdict_d = V_LENGTH;
        end else if (needs_latch && !latch_q) begin
            verdict_d = V_NOWEL;
        // otp mode steers program to otp area
        end else if (otp_q && is_prog) begin
            verdict_d = otp_lk ? V_OTPLOCK : V_EXEC;
        end else if (otp_q && (is_sect || is_b32 || is_blk || is_chip)) begin
            verdict_d = V_OTPLOCK;
        end else if (!otp_q && arr_prot) begin
            verdict_d = V_PROT;
        end
    end

    wire accept  = cmd_valid_i && (verdict_d == V_EXEC);
    wire wrsr_go = accept && is_wrsr;

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    always_comb begin
        case (state_q)
            ST_STANDBY: state_d = cmd_valid_i ? ST_CMD : ST_STANDBY;
            ST_CMD:     state_d = ST_STANDBY;
            ST_DPD: begin
                state_d = ST_DPD;
                if (accept && (cmd_opcode_i == CMD_WAKE
                    || cmd_opcode_i == CMD_RST)) begin
                    state_d = ST_STANDBY;
                end
            end
            default:    state_d = ST_STANDBY;
        endcase
        if (accept && cmd_opcode_i == CMD_DP && state_q != ST_DPD) begin
            state_d = ST_DPD;
        end
    end

    // reset lands in standby, nothing pending
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= ST_STANDBY;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // write enable latch and otp mode
    // ------------------------------------------------------------
    // only a finished, accepted frame changes anything
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            latch_q <= 1'b0;
            otp_q <= 1'b0;
        end else if (accept) begin
            // latch set by enable, cleared by any write
            if (cmd_opcode_i == CMD_WRITE_EN) begin
                latch_q <= 1'b1;
            end else if (needs_latch || cmd_opcode_i == CMD_WRDI
                         || cmd_opcode_i == CMD_RST) begin
                latch_q <= 1'b0;
            end
            if (cmd_opcode_i == CMD_ENSO) begin
                otp_q <= 1'b1;
            end else if (cmd_opcode_i == CMD_EXSO
                         || cmd_opcode_i == CMD_RST) begin
                otp_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // security register
    // ------------------------------------------------------------
    // factory bit follows its input every cycle after reset release, never in reset
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flock_q <= 1'b0;
            clock_q <= 1'b0;
        end else begin
            flock_q <= factory_lock_i;
            if (accept && is_scur) begin
                clock_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // apb slave; bus writes stand for the status register path
    // ------------------------------------------------------------
    wire apb_wr   = psel_i && penable_i && pwrite_i;
    wire apb_rd   = psel_i && !penable_i && !pwrite_i;
    wire hit_ctrl = (paddr_i == REG_CTRL);
    wire hit_stat = (paddr_i == REG_STATUS);
    wire hit_sec  = (paddr_i == REG_SECUR);
    wire hit_last = (paddr_i == REG_LAST);
    wire hit_slk  = (paddr_i == REG_SECTLK);
    wire mapped   = hit_ctrl | hit_stat | hit_sec | hit_last | hit_slk;
    // pin freezes level bits and the lock bit
    wire [7:0] ctrl_keep = pin_lock ? 8'h2F : 8'h00;
    wire [7:0] ctrl_new  = (ctrl_q & ctrl_keep)
                         | (pwdata_i[7:0] & ~ctrl_keep);
    wire [7:0] wrsr_new  = (ctrl_q & (ctrl_keep | 8'hC0))
                         | (cmd_data_i & ~(ctrl_keep | 8'hC0));
    wire [31:0] rd_mux   =
          hit_ctrl ? {24'h000000, ctrl_q}
        : hit_stat ? {24'h000000, 1'b0, state_q, otp_q, latch_q,
                      pin_lock, ~wp_sync_q}
        : hit_sec  ? {30'h0, clock_q, flock_q}
        : hit_last ? {21'h0, verdict_q, last_op_q}
        : hit_slk  ? {16'h0000, sectlk_q}
        : 32'h00000000;

    // register writes come from the bus or an accepted status write
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_q   <= CTRL_RST;
            sectlk_q <= SECTLK_RST;
        end else if (wrsr_go) begin
            ctrl_q   <= wrsr_new;
        end else if (apb_wr && hit_ctrl) begin
            ctrl_q   <= ctrl_new;
        end else if (apb_wr && hit_slk) begin
            sectlk_q <= pwdata_i[15:0];
        end
    end

    // zero-wait slave: answer in the first access cycle
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_o  <= 32'h00000000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !mapped;
            if (apb_rd) begin
                prdata_o <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // verdict outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            exec_o     <= 1'b0;
            exec_otp_o <= 1'b0;
            reject_o   <= 1'b0;
            verdict_q  <= V_NONE;
            last_op_q  <= 8'h00;
        end else begin
            exec_o     <= accept;
            exec_otp_o <= accept && otp_q && is_prog;
            reject_o   <= cmd_valid_i && !accept;
            if (cmd_valid_i) begin
                verdict_q <= verdict_d;
                last_op_q <= cmd_opcode_i;
            end
        end
    end

    assign verdict_o            = verdict_q;
    assign write_enable_latch_o = latch_q;
    assign otp_mode_o           = otp_q;
    assign deep_power_down_o    = state_q[2]; // one-hot power-down flop

endmodule : flash_wp

`default_nettype wire

// >>> flash_wp_properties.sv
// checker: port-level properties of the write-protection gate
`timescale 1ns/10ps
`default_nettype none
module flash_wp_properties
    import flash_wp_pkg::*;
(
    input wire logic       mclk_i,
    input wire logic       reset_n_i,
    input wire logic       cmd_valid_i,
    input wire logic [7:0] cmd_opcode_i,
    input wire logic       cmd_byte_aligned_i,
    input wire logic       psel_i,
    input wire logic       penable_i,
    input wire logic       pready_o,
    input wire logic       pslverr_o,
    input wire logic       exec_o,
    input wire logic       exec_otp_o,
    input wire logic       reject_o,
    input wire logic [2:0] verdict_o,
    input wire logic       write_enable_latch_o,
    input wire logic       otp_mode_o,
    input wire logic       deep_power_down_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    // whole aligned frame outside power-down: the filters below apply
    logic ok_c;
    assign ok_c = cmd_valid_i && cmd_byte_aligned_i && !deep_power_down_o;

    // ----------
    // properties
    // ----------
    a_answer_once: assert property (
        cmd_valid_i |=> exec_o != reject_o)
        else $error("frame not answered exactly once");
    a_no_stray_answer: assert property (
        exec_o || reject_o |-> $past(cmd_valid_i))
        else $error("answer without a frame");
    a_verdict_holds: assert property (
        !$past(cmd_valid_i) |-> $stable(verdict_o))
        else $error("verdict moved without a frame");
    a_length_drop: assert property (
        cmd_valid_i && !cmd_byte_aligned_i && !deep_power_down_o
        |=> reject_o && verdict_o == V_LENGTH)
        else $error("ragged frame not discarded");
    a_latch_needed: assert property (
        ok_c && !write_enable_latch_o && cmd_opcode_i == CMD_PP
        |=> reject_o && verdict_o == V_NOWEL)
        else $error("program accepted with latch clear");
    a_latch_set: assert property (
        ok_c && cmd_opcode_i == CMD_WRITE_EN
        |=> exec_o && write_enable_latch_o)
        else $error("write enable did not set latch");
    a_sleep_filter: assert property (
        cmd_valid_i && deep_power_down_o && cmd_opcode_i == CMD_PP
        |=> reject_o && verdict_o == V_DPD && deep_power_down_o)
        else $error("program obeyed in power-down");
    a_otp_steer: assert property (
        exec_otp_o |-> exec_o && otp_mode_o)
        else $error("otp program outside otp mode");
    a_power_up: assert property (
        $rose(reset_n_i) |-> !write_enable_latch_o && !otp_mode_o
        && !deep_power_down_o && verdict_o == V_NONE)
        else $error("not standby after reset");
    a_bus_answer: assert property (
        psel_i && !penable_i |=> pready_o ##1 !pready_o && !pslverr_o)
        else $error("register access answer timing");
endmodule : flash_wp_properties

bind flash_wp flash_wp_properties u_props (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_opcode_i(cmd_opcode_i), .cmd_byte_aligned_i(cmd_byte_aligned_i),
    .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .exec_o(exec_o), .exec_otp_o(exec_otp_o),
    .reject_o(reject_o), .verdict_o(verdict_o),
    .write_enable_latch_o(write_enable_latch_o),
    .otp_mode_o(otp_mode_o), .deep_power_down_o(deep_power_down_o)
);
`default_nettype wire

// >>> flash_host_model.sv
// model: serial host that hands finished command frames to the gate
`timescale 1ns/10ps
`default_nettype none
module flash_host_model (
    input  wire logic        mclk_i,
    output logic             cmd_valid_o,
    output logic [7:0]       opcode_o,
    output logic [24:0]      addr_o,
    output logic [7:0]       data_o,
    output logic             aligned_o
);
    initial begin
        cmd_valid_o = 1'b0;
        opcode_o = 8'h00;
        addr_o = 25'h0000000;
        data_o = 8'h00;
        aligned_o = 1'b0;
    end

    // fields live one cycle; afterwards they flip so stale values never
    // pass for a frame
    task automatic frame(input logic [7:0] op, input logic [24:0] a,
                         input logic [7:0] d, input logic al);
        @(posedge mclk_i);
        cmd_valid_o <= 1'b1;
        opcode_o <= op;
        addr_o <= a;
        data_o <= d;
        aligned_o <= al;
        @(posedge mclk_i);
        cmd_valid_o <= 1'b0;
        opcode_o <= ~op;
        addr_o <= ~a;
        data_o <= ~d;
        aligned_o <= ~al;
    endtask : frame

    task automatic latched(input logic [7:0] op, input logic [24:0] a);
        frame(8'h06, 25'h0000000, 8'h00, 1'b1);
        frame(op, a, 8'h00, 1'b1);
    endtask : latched
endmodule : flash_host_model
`default_nettype wire

// >>> flash_wp_tb.sv
// testbench: self-checking run of the flash write-protection gate
`timescale 1ns/10ps
`default_nettype none
module flash_wp_tb;
    import flash_wp_pkg::*;
    logic        mclk_i, reset_n_i, factory_lock_i, write_protect_n_i;
    logic        cmd_valid_i, cmd_byte_aligned_i;
    logic [7:0]  cmd_opcode_i, cmd_data_i, paddr_i;
    logic [24:0] cmd_addr_i;
    logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic        exec_o, exec_otp_o, reject_o, err, tbb;
    logic        write_enable_latch_o, otp_mode_o, deep_power_down_o;
    logic [2:0]  verdict_o;
    logic [3:0]  bp;
    logic [1:0]  e;
    int          fail_count, tests_run, cyc, seed, i, n, k, blk;

    flash_host_model host (.mclk_i(mclk_i), .cmd_valid_o(cmd_valid_i),
        .opcode_o(cmd_opcode_i), .addr_o(cmd_addr_i), .data_o(cmd_data_i),
        .aligned_o(cmd_byte_aligned_i));
    flash_wp DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .cmd_valid_i(cmd_valid_i), .cmd_opcode_i(cmd_opcode_i),
        .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i),
        .cmd_byte_aligned_i(cmd_byte_aligned_i),
        .factory_lock_i(factory_lock_i),
        .write_protect_n_i(write_protect_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .exec_o(exec_o), .exec_otp_o(exec_otp_o),
        .reject_o(reject_o), .verdict_o(verdict_o),
        .write_enable_latch_o(write_enable_latch_o),
        .otp_mode_o(otp_mode_o), .deep_power_down_o(deep_power_down_o));

    // ----------
    // helpers
    // ----------
    task automatic close_out();
        if (fail_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            $display("wrong value %s expected %0h seen %0h", nm, x, g);
            fail_count++;
        end
    endtask : chk
    // request held until pready is sampled high, then released
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int t;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        t = 0;
        do begin
            @(posedge mclk_i);
            t++;
        end while (pready_o !== 1'b1);
        // slave answers in the first access cycle
        chk("wait cycles", 1, t);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk("register", x, rd);
    endtask : rchk
    task automatic vchk(input logic [2:0] v);
        chk("verdict", 32'(v), 32'(verdict_o));
        chk("accept", 32'(v == V_EXEC), 32'(exec_o));
        chk("refuse", 32'(v != V_EXEC), 32'(reject_o));
    endtask : vchk
    task automatic cmd(input logic [7:0] op, input logic [24:0] a,
                       input logic al, input logic [2:0] v);
        host.frame(op, a, 8'h00, al);
        #1;
        vchk(v);
    endtask : cmd
    task automatic wcmd(input logic [7:0] op, input logic [24:0] a,
                        input logic [2:0] v);
        host.latched(op, a);
        #1;
        vchk(v);
    endtask : wcmd
    // size of the guarded span in 64K blocks for a protect level
    function automatic int span(input logic [3:0] b);
        return b == 0 ? 0 : b > 9 ? 512 : 1 << (b - 1);
    endfunction : span
    function automatic logic prot(input logic [3:0] b, input logic t,
                                  input int k9);
        return t ? k9 < span(b) : k9 >= 512 - span(b);
    endfunction : prot

    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    // hang guard: whole run needs a few hundred cycles
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            chk("timeout", 0, 1);
            close_out();
        end
    end

    initial begin
        {reset_n_i, psel_i, penable_i, pwrite_i, cyc} = '0;
        {paddr_i, pwdata_i, fail_count, tests_run} = '0;
        factory_lock_i = 1'b1;
        write_protect_n_i = 1'b1;
        seed = 98;
        repeat (12) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rchk(REG_CTRL, 32'h0);
        rchk(REG_SECUR, 32'h1);
        rchk(REG_SECTLK, 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        chk("slverr", 1, 32'(err));
        chk("rdata", 0, rd);
        cmd(CMD_PP, 25'h0, 1'b1, V_NOWEL);
        cmd(CMD_WRITE_EN, 25'h0, 1'b0, V_LENGTH);
        cmd(CMD_WRITE_EN, 25'h0, 1'b1, V_EXEC);
        cmd(CMD_SE, 25'h0, 1'b0, V_LENGTH);
        chk("latch", 1, 32'(write_enable_latch_o));
        cmd(CMD_SE, 25'h0, 1'b1, V_EXEC);
        chk("latch", 0, 32'(write_enable_latch_o));
        // pin low freezes level bits until quad data mode frees it
        apb(1'b1, REG_CTRL, 32'h25);
        write_protect_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        apb(1'b1, REG_CTRL, 32'h0);
        rchk(REG_CTRL, 32'h25);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("pin", 32'h3, rd & 32'h3);
        host.frame(CMD_WRITE_EN, 25'h0, 8'h00, 1'b1);
        host.frame(CMD_WRSR, 25'h0, 8'hD0, 1'b1);
        #1;
        vchk(V_EXEC);
        rchk(REG_CTRL, 32'h35);
        apb(1'b1, REG_CTRL, 32'h50);
        rchk(REG_CTRL, 32'h75);
        apb(1'b1, REG_CTRL, 32'h0);
        rchk(REG_CTRL, 32'h0);
        apb(1'b1, REG_CTRL, 32'hA5);
        apb(1'b1, REG_CTRL, 32'h0);
        rchk(REG_CTRL, 32'h0);
        write_protect_n_i <= 1'b1;
        // every level both ways first, then random; aim at span edges
        for (i = 0; i < 64; i++) begin
            bp = (i < 32) ? 4'(i) : 4'($random(seed));
            tbb = (i < 32) ? i[4] : 1'($random(seed));
            e = 2'($random(seed));
            n = span(bp);
            blk = (e[1] ? 512 - n - int'(e[0]) : n - int'(e[0])) & 511;
            apb(1'b1, REG_CTRL, 32'({tbb, bp}));
            wcmd(i[0] ? CMD_SE : CMD_PP, {9'(blk), 16'($random(seed))},
                 prot(bp, tbb, blk) ? V_PROT : V_EXEC);
        end
        apb(1'b1, REG_CTRL, 32'h0);
        k = $random(seed) & 15;
        apb(1'b1, REG_SECTLK, 32'h1 << k);
        rchk(REG_SECTLK, 32'h1 << k);
        wcmd(CMD_SE, 25'h1FF0000 + 25'(k << 12), V_PROT);
        wcmd(CMD_PP, 25'h1FF0000 + 25'((k ^ 1) << 12), V_EXEC);
        wcmd(CMD_BE32, 25'h1FF0000 + 25'(k << 12), V_PROT);
        wcmd(CMD_BE32, 25'h1FF0000 + 25'((k ^ 8) << 12), V_EXEC);
        wcmd(CMD_BE, 25'h1FF0000, V_PROT);
        wcmd(CMD_CE, 25'h0, V_PROT);
        apb(1'b1, REG_SECTLK, 32'h0);
        wcmd(CMD_CE, 25'h0, V_EXEC);
        wcmd(CMD_DP, 25'h0, V_EXEC);
        cmd(CMD_PP, 25'h0, 1'b1, V_DPD);
        cmd(CMD_WAKE, 25'h0, 1'b1, V_EXEC);
        chk("sleep", 0, 32'(deep_power_down_o));
        // otp: enter, program, exit; then customer lock-down
        wcmd(CMD_ENSO, 25'h0, V_EXEC);
        wcmd(CMD_PP, 25'h010, V_EXEC);
        chk("otp hit", 1, 32'(exec_otp_o));
        wcmd(CMD_PP, 25'h200, V_OTPLOCK);
        wcmd(CMD_SE, 25'h010, V_OTPLOCK);
        wcmd(CMD_EXSO, 25'h0, V_EXEC);
        wcmd(CMD_SECUR_WR, 25'h0, V_EXEC);
        rchk(REG_SECUR, 32'h3);
        wcmd(CMD_ENSO, 25'h0, V_EXEC);
        wcmd(CMD_PP, 25'h010, V_OTPLOCK);
        wcmd(CMD_EXSO, 25'h0, V_EXEC);
        chk("otp mode", 0, 32'(otp_mode_o));
        rchk(REG_LAST, 32'({V_EXEC, CMD_EXSO}));
        close_out();
    end
endmodule : flash_wp_tb
`default_nettype wire
